// >>> scrb_pkg.sv
/*
 * package for the synthesizer calibration register bank: register
 * addresses, field layouts and reset values.
 * assumes an 8-bit register port with 6-bit addresses driven by the
 * device's serial interface logic on the same clock.
 */
package scrb_pkg;
    localparam int SCRB_AW = 6;
    localparam logic [5:0] SCRB_ADDR_VCO_CUR = 6'h24;
    localparam logic [5:0] SCRB_ADDR_VCO_CAP = 6'h25;
    localparam logic [5:0] SCRB_ADDR_CAL_CTL = 6'h26;
    localparam logic [5:0] SCRB_ADDR_RC_A = 6'h27;
    localparam logic [5:0] SCRB_ADDR_RC_B = 6'h28;
    localparam logic [5:0] SCRB_ADDR_SYN_TEST = 6'h29;
    localparam logic [5:0] SCRB_ADDR_PROD_TEST = 6'h2a;
    // writable-bit masks, reserved positions are zero
    localparam logic [7:0] SCRB_MASK_VCO_CUR = 8'h3f;
    localparam logic [7:0] SCRB_MASK_VCO_CAP = 8'h3f;
    localparam logic [7:0] SCRB_MASK_7BIT = 8'h7f;
    localparam logic [7:0] SCRB_MASK_FULL = 8'hff;
    localparam int SCRB_VCO_SEL_BIT = 5;
    localparam logic [7:0] SCRB_RST_VCO_CUR = 8'h0a;
    localparam logic [7:0] SCRB_RST_VCO_CAP = 8'h20;
    localparam logic [7:0] SCRB_RST_CAL_CTL = 8'h0d;
    localparam logic [7:0] SCRB_RST_RC_A = 8'h41;
    localparam logic [7:0] SCRB_RST_RC_B = 8'h00;
    localparam logic [7:0] SCRB_RST_SYN_TEST = 8'h59;
    localparam logic [7:0] SCRB_RST_PROD_TEST = 8'h7f;
    localparam logic [7:0] SCRB_TEMP_SENSOR_KEY = 8'hbf;
endpackage : scrb_pkg

// >>> scrb_bank.sv
/*
 * synthesizer calibration register bank: seven 8-bit registers at
 * 0x24..0x2a with calibration load path and sleep-loss behaviour.
 * assumes register port strobes and calibration results come from
 * logic on i_clk; i_wake_pulse is a one-cycle pulse from the radio
 * control state machine on leaving sleep.
 */
module scrb_bank
    import scrb_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // register port
    input wire logic i_wr_en,
    input wire logic [5:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // calibration engine result load
    input wire logic i_cal_load,
    input wire logic i_cal_vco_high,
    input wire logic [4:0] i_cal_vco_current,
    input wire logic [5:0] i_cal_vco_cap,
    // radio state
    input wire logic i_wake_pulse,
    input wire logic i_state_idle,
    // fields to synthesizer, vco and rc oscillator
    output logic o_vco_high_core_select,
    output logic [4:0] o_vco_current,
    output logic [5:0] o_vco_coarse_cap,
    output logic [6:0] o_cal_control,
    output logic [6:0] o_rc_config_a,
    output logic [6:0] o_rc_config_b,
    output logic [7:0] o_synth_test,
    output logic o_temp_sensor_en
);
    localparam int NREG = 7;

    function automatic logic [7:0] reg_mask(input int idx);
        case (idx)
            0: reg_mask = SCRB_MASK_VCO_CUR;
            1: reg_mask = SCRB_MASK_VCO_CAP;
            2, 3, 4: reg_mask = SCRB_MASK_7BIT;
            default: reg_mask = SCRB_MASK_FULL;
        endcase
    endfunction : reg_mask

    function automatic logic [7:0] reg_reset(input int idx);
        case (idx)
            0: reg_reset = SCRB_RST_VCO_CUR;
            1: reg_reset = SCRB_RST_VCO_CAP;
            2: reg_reset = SCRB_RST_CAL_CTL;
            3: reg_reset = SCRB_RST_RC_A;
            4: reg_reset = SCRB_RST_RC_B;
            5: reg_reset = SCRB_RST_SYN_TEST;
            default: reg_reset = SCRB_RST_PROD_TEST;
        endcase
    endfunction : reg_reset

    logic [7:0] regs_q [NREG];
    logic [7:0] regs_d [NREG];
    logic addr_hit;
    logic [2:0] addr_idx;

    assign addr_hit = (i_addr >= SCRB_ADDR_VCO_CUR) && (i_addr <= SCRB_ADDR_PROD_TEST);
    assign addr_idx = 3'(i_addr - SCRB_ADDR_VCO_CUR);

    always_comb
    begin
        for (int i = 0; i < NREG; i++)
        begin
            regs_d[i] = regs_q[i];
            // host write wins over a calibration load in the same cycle
            if (i_wr_en && addr_hit && (int'(addr_idx) == i))
            begin
                regs_d[i] = i_wdata & reg_mask(i);
            end
            else if (i_cal_load && (i == 0))
            begin
                regs_d[i] = {2'b00, i_cal_vco_high, i_cal_vco_current};
            end
            else if (i_cal_load && (i == 1))
            begin
                regs_d[i] = {2'b00, i_cal_vco_cap};
            end
            // volatile test registers lose programming across sleep
            if (i_wake_pulse && (i >= 5))
            begin
                regs_d[i] = reg_reset(i);
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        for (int i = 0; i < NREG; i++)
        begin
            if (!i_rst_b)
            begin
                regs_q[i] <= reg_reset(i);
            end
            else
            begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    always_comb
    begin
        o_rdata = 8'h00; // unmapped addresses read zero
        if (addr_hit)
        begin
            o_rdata = regs_q[addr_idx];
        end
    end

    assign o_vco_high_core_select = regs_q[0][SCRB_VCO_SEL_BIT];
    assign o_vco_current = regs_q[0][4:0];
    assign o_vco_coarse_cap = regs_q[1][5:0];
    assign o_cal_control = regs_q[2][6:0];
    assign o_rc_config_a = regs_q[3][6:0];
    assign o_rc_config_b = regs_q[4][6:0];
    assign o_synth_test = regs_q[5];
    // sensor only exposed in idle; host restores 0x7f before leaving
    assign o_temp_sensor_en = i_state_idle && (regs_q[6] == SCRB_TEMP_SENSOR_KEY);

    a_vco_write_used: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_wr_en && i_addr == SCRB_ADDR_VCO_CUR && !i_wake_pulse
        |=> o_vco_current == $past(i_wdata[4:0])
            && o_vco_high_core_select == $past(i_wdata[5]))
        else $error("vco current write not applied");
    a_cur_override: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_cal_load && !(i_wr_en && i_addr == SCRB_ADDR_VCO_CUR)
        |=> o_vco_current == $past(i_cal_vco_current))
        else $error("vco current result not loaded");
    a_cap_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_wr_en && i_addr == SCRB_ADDR_VCO_CAP
        |=> o_vco_coarse_cap == $past(i_wdata[5:0]))
        else $error("coarse capacitor write not applied");
    a_cap_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !i_cal_load && !(i_wr_en && i_addr == SCRB_ADDR_VCO_CAP)
        |=> $stable(o_vco_coarse_cap))
        else $error("coarse capacitor changed without cause");
    a_cal_ctl_reset: assert property (@(posedge i_clk)
        !i_rst_b |=> o_cal_control == SCRB_RST_CAL_CTL[6:0])
        else $error("calibration control reset wrong");
    a_rc_reset: assert property (@(posedge i_clk)
        !i_rst_b |=> o_rc_config_a == SCRB_RST_RC_A[6:0]
            && o_rc_config_b == SCRB_RST_RC_B[6:0])
        else $error("rc oscillator reset wrong");
    a_wake_restore: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_wake_pulse |=> o_synth_test == SCRB_RST_SYN_TEST
            && !o_temp_sensor_en)
        else $error("test registers not restored on wake");
    a_temp_sensor: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_wr_en && i_addr == SCRB_ADDR_PROD_TEST && i_wdata == SCRB_TEMP_SENSOR_KEY
        && !i_wake_pulse ##1 i_state_idle |-> o_temp_sensor_en)
        else $error("temperature sensor not enabled");
    a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_addr >= SCRB_ADDR_VCO_CUR && i_addr <= SCRB_ADDR_RC_B
        |-> o_rdata[7] == 1'b0)
        else $error("reserved bit reads nonzero");

    // reset values as seen by the synthesizer, not only through the read port
    a_vco_cur_reset: assert property (@(posedge i_clk)
        !i_rst_b
        |=> o_vco_current == SCRB_RST_VCO_CUR[4:0]
            && o_vco_high_core_select == SCRB_RST_VCO_CUR[SCRB_VCO_SEL_BIT])
        else $error("vco current reset wrong");

    a_cap_reset: assert property (@(posedge i_clk)
        !i_rst_b
        |=> o_vco_coarse_cap == SCRB_RST_VCO_CAP[5:0])
        else $error("coarse capacitor reset wrong");

    a_test_reset: assert property (@(posedge i_clk)
        !i_rst_b
        |=> o_synth_test == SCRB_RST_SYN_TEST && !o_temp_sensor_en)
        else $error("test register reset wrong");

    // a calibration result must reach the vco unless the host overrides it
    a_sel_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_cal_load && !(i_wr_en && i_addr == SCRB_ADDR_VCO_CUR)
        |=> o_vco_high_core_select == $past(i_cal_vco_high))
        else $error("vco select result not loaded");

    a_cap_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_cal_load && !(i_wr_en && i_addr == SCRB_ADDR_VCO_CAP)
        |=> o_vco_coarse_cap == $past(i_cal_vco_cap))
        else $error("coarse capacitor result not loaded");

    // saved values only survive a hop if nothing else disturbs them
    a_cur_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !i_cal_load && !(i_wr_en && i_addr == SCRB_ADDR_VCO_CUR)
        |=> $stable(o_vco_current) && $stable(o_vco_high_core_select))
        else $error("vco current changed without cause");

    a_cal_ctl_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_wr_en && i_addr == SCRB_ADDR_CAL_CTL
        |=> o_cal_control == $past(i_wdata[6:0]))
        else $error("calibration control write not applied");

    a_cal_ctl_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !(i_wr_en && i_addr == SCRB_ADDR_CAL_CTL)
        |=> $stable(o_cal_control))
        else $error("calibration control changed without write");

    a_rc_a_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_wr_en && i_addr == SCRB_ADDR_RC_A
        |=> o_rc_config_a == $past(i_wdata[6:0]))
        else $error("rc oscillator a write not applied");

    a_rc_b_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_wr_en && i_addr == SCRB_ADDR_RC_B
        |=> o_rc_config_b == $past(i_wdata[6:0]))
        else $error("rc oscillator b write not applied");

    // the rc oscillator is not touched by sleep or calibration in this bank
    a_rc_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !(i_wr_en && (i_addr == SCRB_ADDR_RC_A || i_addr == SCRB_ADDR_RC_B))
        |=> $stable(o_rc_config_a) && $stable(o_rc_config_b))
        else $error("rc oscillator changed without write");

    a_synth_test_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !i_wake_pulse && !(i_wr_en && i_addr == SCRB_ADDR_SYN_TEST)
        |=> $stable(o_synth_test))
        else $error("synth test changed without cause");

    a_wake_beats_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_wake_pulse && i_wr_en && i_addr == SCRB_ADDR_PROD_TEST
        |=> !o_temp_sensor_en)
        else $error("write survived wake");

    // outside idle the sensor stays off whatever the key register holds
    a_sensor_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !i_state_idle
        |-> !o_temp_sensor_en)
        else $error("temperature sensor on outside idle");

    a_sensor_restore: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_wr_en && i_addr == SCRB_ADDR_PROD_TEST && i_wdata == SCRB_RST_PROD_TEST
        |=> !o_temp_sensor_en)
        else $error("temperature sensor left on after restore");

    a_unmapped_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !(i_addr >= SCRB_ADDR_VCO_CUR && i_addr <= SCRB_ADDR_PROD_TEST)
        |-> o_rdata == 8'h00)
        else $error("unmapped address reads nonzero");

    a_reserved_vco: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_addr == SCRB_ADDR_VCO_CUR || i_addr == SCRB_ADDR_VCO_CAP
        |-> o_rdata[7:6] == 2'b00)
        else $error("reserved vco bits read nonzero");

    // the read port and the field outputs come from the same flip-flops
    a_rdata_vco: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_addr == SCRB_ADDR_VCO_CUR
        |-> o_rdata == {2'b00, o_vco_high_core_select, o_vco_current})
        else $error("vco read differs from output");

    a_rdata_cal_ctl: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_addr == SCRB_ADDR_CAL_CTL
        |-> o_rdata == {1'b0, o_cal_control})
        else $error("calibration control read differs");

    a_rdata_rc: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_addr == SCRB_ADDR_RC_A
        |-> o_rdata == {1'b0, o_rc_config_a})
        else $error("rc oscillator read differs");

    a_rdata_synth: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_addr == SCRB_ADDR_SYN_TEST
        |-> o_rdata == o_synth_test)
        else $error("synth test read differs");
endmodule : scrb_bank

// >>> tb_scrb_bank.sv
/*
 * self-checking bench for the synthesizer calibration register bank.
 * assumes scrb_pkg and scrb_bank are compiled first; inputs change on falling edges, apart from the 1 ns steps of the reset read sweep and the idle check.
 */
module tb_scrb_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import scrb_pkg::*;
    logic i_clk, i_rst_b, i_wr_en, i_cal_load, i_cal_vco_high, i_wake_pulse, i_state_idle;
    logic [5:0] i_addr, i_cal_vco_cap, o_vco_coarse_cap;
    logic [7:0] i_wdata, o_rdata, o_synth_test;
    logic [4:0] i_cal_vco_current, o_vco_current;
    logic o_vco_high_core_select, o_temp_sensor_en;
    logic [6:0] o_cal_control, o_rc_config_a, o_rc_config_b;
    int n_fail = 0;
    int num_checks = 0;
    // rows: {2'b0, address}, written byte, expected read-back
    logic [23:0] rows [12] = '{24'h24ff3f, 24'h241515, 24'h25ff3f, 24'h251313, 24'h26ff7f,
        24'h268000, 24'h27ff7f, 24'h28ff7f, 24'h282a2a, 24'h29a5a5, 24'h3fff00, 24'h235500};
    logic [7:0] rst_val [7] = '{SCRB_RST_VCO_CUR, SCRB_RST_VCO_CAP, SCRB_RST_CAL_CTL,
        SCRB_RST_RC_A, SCRB_RST_RC_B, SCRB_RST_SYN_TEST, SCRB_RST_PROD_TEST};
    scrb_bank scrb_bank_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr_en(i_wr_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_cal_load(i_cal_load),
        .i_cal_vco_high(i_cal_vco_high), .i_cal_vco_current(i_cal_vco_current),
        .i_cal_vco_cap(i_cal_vco_cap), .i_wake_pulse(i_wake_pulse),
        .i_state_idle(i_state_idle), .o_vco_high_core_select(o_vco_high_core_select),
        .o_vco_current(o_vco_current), .o_vco_coarse_cap(o_vco_coarse_cap),
        .o_cal_control(o_cal_control), .o_rc_config_a(o_rc_config_a),
        .o_rc_config_b(o_rc_config_b), .o_synth_test(o_synth_test),
        .o_temp_sensor_en(o_temp_sensor_en));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // write on one edge; the read mux then shows the same address
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic wake = 1'b0);
        @(negedge i_clk);
        i_wr_en = 1'b1;
        i_addr = a;
        i_wdata = d;
        i_wake_pulse = wake;
        @(negedge i_clk);
        i_wr_en = 1'b0;
        i_wake_pulse = 1'b0;
    endtask : wr
    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial
    begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        final_report();
    end
    initial
    begin
        {i_rst_b, i_wr_en, i_cal_load, i_cal_vco_high, i_wake_pulse} = '0;
        {i_addr, i_wdata, i_cal_vco_current, i_cal_vco_cap} = '0;
        i_state_idle = 1'b1;
        repeat (4) @(negedge i_clk);
        i_rst_b = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            i_addr = 6'h24 + 6'(i);
            #1 chk(o_rdata, rst_val[i], "reset value");
        end
        chk({7'h0, o_temp_sensor_en}, 8'h00, "sensor off after reset");
        foreach (rows[i])
        begin
            wr(rows[i][21:16], rows[i][15:8]);
            chk(o_rdata, rows[i][7:0], "read-back");
        end
        wr(6'h24, 8'h2b);
        chk({o_vco_high_core_select, o_vco_current}, 8'h2b, "vco select/current");
        chk({1'b0, o_cal_control}, 8'h00, "cal control out");
        chk({1'b0, o_rc_config_a}, 8'h7f, "rc a out");
        chk({1'b0, o_rc_config_b}, 8'h2a, "rc b out");
        chk(o_synth_test, 8'ha5, "synth test out");
        // calibration result loads, then a host write in the same cycle must win on 0x25
        @(negedge i_clk);
        {i_cal_load, i_cal_vco_high, i_cal_vco_current, i_cal_vco_cap} = {2'b10, 5'h1e, 6'h2d};
        wr(6'h25, 8'h07);
        i_cal_load = 1'b0;
        chk({o_vco_high_core_select, o_vco_current}, 8'h1e, "cal load 0x24");
        chk({2'b0, o_vco_coarse_cap}, 8'h07, "host write beats load");
        wr(6'h24, 8'h31);
        chk({o_vco_high_core_select, o_vco_current}, 8'h31, "hop restore");
        wr(6'h2a, SCRB_TEMP_SENSOR_KEY);
        chk({7'h0, o_temp_sensor_en}, 8'h01, "sensor on in idle");
        i_state_idle = 1'b0;
        #1 chk({7'h0, o_temp_sensor_en}, 8'h00, "sensor off outside idle");
        i_state_idle = 1'b1;
        // wake restores both test registers, 0x2a even against a same-cycle write to it
        wr(6'h2a, 8'hbf, 1'b1);
        chk(o_rdata, SCRB_RST_PROD_TEST, "wake prod test");
        chk(o_synth_test, SCRB_RST_SYN_TEST, "wake synth test");
        chk({7'h0, o_temp_sensor_en}, 8'h00, "sensor off after wake");
        wr(6'h2a, 8'hbf);
        wr(6'h2a, SCRB_RST_PROD_TEST);
        chk({7'h0, o_temp_sensor_en}, 8'h00, "sensor off after restore");
        wr(6'h24, 8'h3f);
        i_rst_b = 1'b0;
        @(negedge i_clk);
        i_rst_b = 1'b1;
        chk(o_rdata, SCRB_RST_VCO_CUR, "mid-run reset");
        final_report();
    end
endmodule : tb_scrb_bank
